// [src/scre_cfg.svh]
`ifndef SCRE_CFG_SVH
`define SCRE_CFG_SVH

`define SCRE_N_IN        10
`define SCRE_N_OUT       16
`define SCRE_N_RULE      8
`define SCRE_CLK_HZ      20000000
`define SCRE_TICK_MS     100
`define SCRE_TICK_CYC    (`SCRE_CLK_HZ / 1000 * `SCRE_TICK_MS)
`define SCRE_TICKS_PER_S (1000 / `SCRE_TICK_MS)

`define SCRE_BANK_CORE   2'h0
`define SCRE_BANK_INCFG  2'h1
`define SCRE_BANK_OUTCFG 2'h2
`define SCRE_BANK_RULE   2'h3
`define SCRE_REG_CTRL    4'h0
`define SCRE_REG_INSTAT  4'h1
`define SCRE_REG_RULEST  4'h2
`define SCRE_REG_OUTST   4'h3

`define SCRE_CTRL_REN    0
`define SCRE_CTRL_RST    1
`define SCRE_CTRL_RESET  1'h0

`define SCRE_IN_MODE_LO  0
`define SCRE_IN_MODE_HI  3
`define SCRE_IN_FUNC_LO  4
`define SCRE_IN_FUNC_HI  5
`define SCRE_IN_EXEMPT   6
`define SCRE_IN_RESET    7'h00

`define SCRE_OUT_CLS_LO  0
`define SCRE_OUT_CLS_HI  1
`define SCRE_OUT_IDX_LO  2
`define SCRE_OUT_IDX_HI  5
`define SCRE_OUT_POL     6
`define SCRE_OUT_RESET   7'h00

`define SCRE_R_SRCA_LO   0
`define SCRE_R_SRCA_HI   5
`define SCRE_R_SRCB_LO   6
`define SCRE_R_SRCB_HI   11
`define SCRE_R_SENSEA    12
`define SCRE_R_SENSEB    13
`define SCRE_R_OP_LO     14
`define SCRE_R_OP_HI     15
`define SCRE_R_DLY_LO    16
`define SCRE_R_DLY_HI    18
`define SCRE_R_LATCH     19
`define SCRE_R_LOG       20
`define SCRE_R_SEV_LO    21
`define SCRE_R_SEV_HI    22
`define SCRE_R_EN        23
`define SCRE_RULE_RESET  24'h000000

`endif

// [src/scre_pkg.sv]
package scre_pkg;
  typedef enum logic [1:0] {
    SCRE_OP_NONE,
    SCRE_OP_AND,
    SCRE_OP_OR,
    SCRE_OP_XOR
  } scre_op_t;

  typedef enum logic [1:0] {
    SCRE_OUT_NONE,
    SCRE_OUT_ALARM,
    SCRE_OUT_STATUS,
    SCRE_OUT_RULE
  } scre_out_cls_t;

  typedef enum logic [1:0] {
    SCRE_FN_NONE,
    SCRE_FN_CUSTOM,
    SCRE_FN_RESET,
    SCRE_FN_OTHER
  } scre_in_fn_t;

  typedef enum logic [3:0] {
    SCRE_IM_LVL_HI,
    SCRE_IM_LVL_LO,
    SCRE_IM_RISE_ON,
    SCRE_IM_FALL_ON,
    SCRE_IM_RISE_OFF,
    SCRE_IM_FALL_OFF,
    SCRE_IM_RISE_TGL,
    SCRE_IM_FALL_TGL,
    SCRE_IM_RISE_ON_FALL_OFF,
    SCRE_IM_FALL_ON_RISE_OFF
  } scre_in_mode_t;
endpackage

// [src/scre_site_ctrl.sv]
// How it works
// R1: Ten inputs act only when remote enabled; inputs with the exempt bit set act regardless
// R2: Sixteen outputs, assignable source, selectable polarity
// R3: Input and output config, level readable
// R4: Rule delay immediate or 1..60 seconds
// R5: Latch holds assertion until a reset
// R6: Log option raises alarm and log event
// R7: Three-level severity reported with log event
// R8: Rule input from alarm, status, custom
// R9: Sense true or false per rule input
// R10: No operator uses first input only
// R11: AND needs both inputs asserted
// R12: OR needs either input asserted
// R13: XOR needs exactly one input asserted
// R14: Rule asserted state readable as status
// R15: Output can follow a rule state
// R16: Custom remote inputs usable in rules
// R17: Level, edge on/off and toggle modes
// R18: Low-when-true polarity drives pin low
// R19: Early drop restarts the delay count
// R20: Reset clears latched rules no longer active
// R21: Rules timed on a fixed time base
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`include "scre_cfg.svh"

module scre_site_ctrl #(
  parameter int TICK_CYCLES = `SCRE_TICK_CYC
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [9:0]  rin,
  input  wire logic [15:0] alarm_in,
  input  wire logic [15:0] status_in,
  input  wire logic        local_reset,
  output logic      [15:0] rout,
  output logic             rule_alarm,
  output logic             log_evt,
  output logic      [2:0]  log_rule,
  output logic      [1:0]  log_sev
);

  localparam int NI = `SCRE_N_IN;
  localparam int NO = `SCRE_N_OUT;
  localparam int NR = `SCRE_N_RULE;

  // Bus slave: one wait state, then the access completes
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        ren_q;
  logic        lrst_q;
  logic [6:0]  in_cfg_q   [NI];
  logic [6:0]  out_cfg_q  [NO];
  logic [23:0] rule_cfg_q [NR];

  wire         acc_go = (avs_read | avs_write) & wait_q;
  wire         wr_go  = avs_write & ~wait_q;
  wire  [1:0]  bank   = avs_address[7:6];
  wire  [3:0]  idx    = avs_address[5:2];
  wire         hit_ctrl = (bank == `SCRE_BANK_CORE) &&
                          (idx == `SCRE_REG_CTRL);
  wire         hit_in   = (bank == `SCRE_BANK_INCFG) && (idx < 4'hA);
  wire         hit_out  = (bank == `SCRE_BANK_OUTCFG);
  wire         hit_rule = (bank == `SCRE_BANK_RULE) && (idx < 4'h8);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 1'h1;
    end else if (ce) begin
      wait_q <= ~acc_go;
    end
  end

  // Control register and local reset pulse
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ren_q  <= `SCRE_CTRL_RESET;
      lrst_q <= 1'h0;
    end else if (ce) begin
      lrst_q <= local_reset |
                (wr_go & hit_ctrl & avs_writedata[`SCRE_CTRL_RST]);
      if (wr_go && hit_ctrl) begin
        ren_q <= avs_writedata[`SCRE_CTRL_REN];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NI; i++) in_cfg_q[i] <= `SCRE_IN_RESET;
      for (int i = 0; i < NO; i++) out_cfg_q[i] <= `SCRE_OUT_RESET;
      for (int i = 0; i < NR; i++) rule_cfg_q[i] <= `SCRE_RULE_RESET;
    end else if (ce && wr_go) begin
      if (hit_in) in_cfg_q[idx] <= avs_writedata[6:0];
      if (hit_out) out_cfg_q[idx] <= avs_writedata[6:0];
      if (hit_rule) rule_cfg_q[idx[2:0]] <= avs_writedata[23:0];
    end
  end

  // Time base
  logic [31:0] pre_q;
  logic        tick_q;
  wire         pre_end = (pre_q >= 32'(TICK_CYCLES - 1));

  // R21: fixed time base
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pre_q  <= 32'h0;
      tick_q <= 1'h0;
    end else if (ce) begin
      pre_q  <= pre_end ? 32'h0 : pre_q + 32'h1;
      tick_q <= pre_end;
    end
  end

  // Remote inputs
  logic [NI-1:0] pin_q;
  logic [NI-1:0] act_q;
  logic [NI-1:0] eff;
  logic [NI-1:0] custom;
  logic [NI-1:0] rst_req;
  logic          sys_rst_q;

  for (genvar i = 0; i < NI; i++) begin : g_in
    wire [3:0] mode = in_cfg_q[i][`SCRE_IN_MODE_HI:`SCRE_IN_MODE_LO];
    wire [1:0] fn   = in_cfg_q[i][`SCRE_IN_FUNC_HI:`SCRE_IN_FUNC_LO];
    wire       rise = rin[i] & ~pin_q[i];
    wire       fall = ~rin[i] & pin_q[i];
    logic      act_d;
    logic      eff_prev_q;

    // R17: level, edge and toggle modes
    always_comb begin
      act_d = act_q[i];
      unique case (scre_pkg::scre_in_mode_t'(mode))
        scre_pkg::SCRE_IM_LVL_HI:   act_d = rin[i];
        scre_pkg::SCRE_IM_LVL_LO:   act_d = ~rin[i];
        scre_pkg::SCRE_IM_RISE_ON:  if (rise) act_d = 1'h1;
        scre_pkg::SCRE_IM_FALL_ON:  if (fall) act_d = 1'h1;
        scre_pkg::SCRE_IM_RISE_OFF: if (rise) act_d = 1'h0;
        scre_pkg::SCRE_IM_FALL_OFF: if (fall) act_d = 1'h0;
        scre_pkg::SCRE_IM_RISE_TGL: if (rise) act_d = ~act_q[i];
        scre_pkg::SCRE_IM_FALL_TGL: if (fall) act_d = ~act_q[i];
        scre_pkg::SCRE_IM_RISE_ON_FALL_OFF: begin
          if (rise) act_d = 1'h1;
          else if (fall) act_d = 1'h0;
        end
        scre_pkg::SCRE_IM_FALL_ON_RISE_OFF: begin
          if (fall) act_d = 1'h1;
          else if (rise) act_d = 1'h0;
        end
        default: act_d = 1'h0;
      endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        pin_q[i]   <= 1'h0;
        act_q[i]   <= 1'h0;
        eff_prev_q <= 1'h0;
      end else if (ce) begin
        pin_q[i]   <= rin[i];
        act_q[i]   <= act_d;
        eff_prev_q <= eff[i];
      end
    end

    // R1: gated by remote enable unless exempt
    assign eff[i] = act_q[i] & (ren_q | in_cfg_q[i][`SCRE_IN_EXEMPT]);
    // R16: custom inputs feed the rule sources
    assign custom[i] = eff[i] &
                       (fn == 2'(scre_pkg::SCRE_FN_CUSTOM));
    assign rst_req[i] = eff[i] & ~eff_prev_q &
                        (fn == 2'(scre_pkg::SCRE_FN_RESET));
  end

  // R20: local or remote reset pulse
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sys_rst_q <= 1'h0;
    end else if (ce) begin
      sys_rst_q <= lrst_q | (|rst_req);
    end
  end

  // Source code indexes this vector directly
  wire [63:0] src_vec = {22'h0, custom, status_in, alarm_in};

  logic [NR-1:0] cond;
  logic [NR-1:0] asrt_q;
  logic [NR-1:0] new_log;
  logic [NR-1:0] log_alarm;

  for (genvar r = 0; r < NR; r++) begin : g_rule
    wire [23:0] c = rule_cfg_q[r];
    wire [2:0]  dly = c[`SCRE_R_DLY_HI:`SCRE_R_DLY_LO];
    // R8: any alarm, status or custom input
    wire a_raw = src_vec[c[`SCRE_R_SRCA_HI:`SCRE_R_SRCA_LO]];
    wire b_raw = src_vec[c[`SCRE_R_SRCB_HI:`SCRE_R_SRCB_LO]];
    // R9: true sense passes, false sense inverts
    wire a = ~(a_raw ^ c[`SCRE_R_SENSEA]);
    wire b = ~(b_raw ^ c[`SCRE_R_SENSEB]);
    logic [9:0] lim;
    logic [9:0] cnt_q;
    logic       comb_v;

    // R4: delay menu in seconds, in ticks
    always_comb begin
      unique case (dly)
        3'h0:    lim = 10'h000;
        3'h1:    lim = 10'(1 * `SCRE_TICKS_PER_S);
        3'h2:    lim = 10'(2 * `SCRE_TICKS_PER_S);
        3'h3:    lim = 10'(5 * `SCRE_TICKS_PER_S);
        3'h4:    lim = 10'(10 * `SCRE_TICKS_PER_S);
        3'h5:    lim = 10'(30 * `SCRE_TICKS_PER_S);
        default: lim = 10'(60 * `SCRE_TICKS_PER_S);
      endcase
    end

    always_comb begin
      unique case (scre_pkg::scre_op_t'(c[`SCRE_R_OP_HI:`SCRE_R_OP_LO]))
        // R10: single input
        scre_pkg::SCRE_OP_NONE: comb_v = a;
        // R11: both asserted
        scre_pkg::SCRE_OP_AND:  comb_v = a & b;
        // R12: either asserted
        scre_pkg::SCRE_OP_OR:   comb_v = a | b;
        // R13: exactly one asserted
        scre_pkg::SCRE_OP_XOR:  comb_v = a ^ b;
      endcase
    end

    assign cond[r] = comb_v & c[`SCRE_R_EN];
    wire met = cond[r] & (cnt_q >= lim);
    // R5: latch holds; R20: reset frees it once inactive
    wire asrt_d = met | (c[`SCRE_R_LATCH] & asrt_q[r] &
                         ~(sys_rst_q & ~cond[r]));

    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        cnt_q     <= 10'h000;
        asrt_q[r] <= 1'h0;
      end else if (ce) begin
        // R19: inactive condition restarts count
        if (!cond[r]) cnt_q <= 10'h000;
        else if (tick_q && cnt_q < lim) cnt_q <= cnt_q + 10'h001;
        asrt_q[r] <= asrt_d;
      end
    end

    // R6: log only on the asserting edge
    assign new_log[r] = asrt_d & ~asrt_q[r] & c[`SCRE_R_LOG];
    // R6: next state, so alarm never lags the event
    assign log_alarm[r] = asrt_d & c[`SCRE_R_LOG];
  end

  // Log reporting; lowest rule wins a same-cycle tie
  logic [2:0] lsel;
  always_comb begin
    lsel = 3'h0;
    for (int r = NR - 1; r >= 0; r--) begin
      if (new_log[r]) lsel = 3'(r);
    end
  end

  // R6: alarm and event; R7: severity with it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      log_evt    <= 1'h0;
      log_rule   <= 3'h0;
      log_sev    <= 2'h0;
      rule_alarm <= 1'h0;
    end else if (ce) begin
      log_evt    <= |new_log;
      rule_alarm <= |log_alarm;
      if (|new_log) begin
        log_rule <= lsel;
        log_sev  <= rule_cfg_q[lsel][`SCRE_R_SEV_HI:`SCRE_R_SEV_LO];
      end
    end
  end

  // Remote outputs
  logic [NO-1:0] out_d;
  for (genvar j = 0; j < NO; j++) begin : g_out
    wire [1:0] cls = out_cfg_q[j][`SCRE_OUT_CLS_HI:`SCRE_OUT_CLS_LO];
    wire [3:0] oi  = out_cfg_q[j][`SCRE_OUT_IDX_HI:`SCRE_OUT_IDX_LO];
    logic      val;
    // R2: source per output; R15: rule as channel
    always_comb begin
      unique case (scre_pkg::scre_out_cls_t'(cls))
        scre_pkg::SCRE_OUT_NONE:   val = 1'h0;
        scre_pkg::SCRE_OUT_ALARM:  val = alarm_in[oi];
        scre_pkg::SCRE_OUT_STATUS: val = status_in[oi];
        scre_pkg::SCRE_OUT_RULE:   val = oi[3] ? 1'h0 : asrt_q[oi[2:0]];
      endcase
    end
    // R18: polarity set means low when true
    assign out_d[j] = val ^ out_cfg_q[j][`SCRE_OUT_POL];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rout <= 16'h0000;
    end else if (ce) begin
      rout <= out_d;
    end
  end

  // R3: config and pin levels readable; R14: rule state
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (bank)
      `SCRE_BANK_CORE: begin
        if (idx == `SCRE_REG_CTRL) rd_mux = {31'h0, ren_q};
        if (idx == `SCRE_REG_INSTAT) rd_mux = {6'h0, eff, 6'h0, pin_q};
        if (idx == `SCRE_REG_RULEST) rd_mux = {16'h0, cond, asrt_q};
        if (idx == `SCRE_REG_OUTST) rd_mux = {16'h0, rout};
      end
      `SCRE_BANK_INCFG:
        if (hit_in) rd_mux = {25'h0, in_cfg_q[idx]};
      `SCRE_BANK_OUTCFG: rd_mux = {25'h0, out_cfg_q[idx]};
      `SCRE_BANK_RULE:
        if (hit_rule) rd_mux = {8'h0, rule_cfg_q[idx[2:0]]};
    endcase
  end

  // Read data registered so it comes straight from a flop
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 32'h00000000;
    end else if (ce && acc_go && avs_read) begin
      rdata_q <= rd_mux;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

endmodule

// [bench/scre_site_equip.sv]
module scre_site_equip (
  input  wire logic        mclk,
  input  wire logic [8:0]  drive,
  input  wire logic [15:0] rout,
  output logic      [9:0]  rin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pin 9 reports back output 0 inverted, as a cooler confirming it runs
  always @(posedge mclk) begin
    rin <= {~rout[0], drive};
  end
endmodule

// [bench/scre_site_ctrl_checker.sv]
module scre_site_ctrl_checker (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        ce,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        rule_alarm,
  input wire logic        log_evt,
  input wire logic [2:0]  log_rule,
  input wire logic [1:0]  log_sev
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  // A frozen clock enable stalls everything, so nothing is judged then
  default disable iff (!arst_n || !ce);
  wire logic req = avs_read || avs_write;
  wait_one_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  wait_back_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  idle_wait_a: assert property (!req && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  rdata_src_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("read data moved without read");
  log_alarm_a: assert property (log_evt |-> rule_alarm)
    else $error("log event without alarm");
  alarm_log_a: assert property ($rose(rule_alarm) |-> log_evt)
    else $error("alarm rose without log event");
  rule_hold_a: assert property ($changed(log_rule) |-> log_evt)
    else $error("log rule moved without event");
  sev_hold_a: assert property ($changed(log_sev) |-> log_evt)
    else $error("log severity moved without event");
  cover property (log_evt);
  cover property (avs_write && !avs_waitrequest);
  cover property ($fell(rule_alarm));
endmodule

bind scre_site_ctrl scre_site_ctrl_checker chk_u (
  .mclk            (mclk),
  .arst_n          (arst_n),
  .ce              (ce),
  .avs_read        (avs_read),
  .avs_write       (avs_write),
  .avs_readdata    (avs_readdata),
  .avs_waitrequest (avs_waitrequest),
  .rule_alarm      (rule_alarm),
  .log_evt         (log_evt),
  .log_rule        (log_rule),
  .log_sev         (log_sev)
);

// [bench/scre_site_ctrl_test.sv]
`define SCRE_CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); \
  end \
end

module scre_site_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk;
  logic        arst_n;
  logic [7:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wait_req;
  logic [9:0]  rin;
  logic [8:0]  drive;
  logic [15:0] alarm;
  logic [15:0] status;
  logic        lrst;
  logic        ce;
  logic        ralm;
  logic [15:0] rout;
  logic        evt;
  logic [2:0]  lrule;
  logic [1:0]  lsev;
  logic [63:0] rq[$];
  logic [4:0]  lq[$];
  logic [63:0] n;
  logic [4:0]  l;
  logic [31:0] r;
  logic [31:0] v;
  logic [31:0] w;
  logic [15:0] o;
  logic [1:0]  op;
  logic        ea;
  logic        eb;
  logic        c;
  int          s;
  int          errors;
  int          num_checks;
  int          seed;

  scre_site_ctrl #(.TICK_CYCLES(4)) dut_u (
    .mclk(mclk), .arst_n(arst_n), .ce(ce), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_readdata(rdata), .avs_waitrequest(wait_req), .rin(rin),
    .alarm_in(alarm), .status_in(status), .local_reset(lrst),
    .rout(rout), .rule_alarm(ralm), .log_evt(evt), .log_rule(lrule),
    .log_sev(lsev)
  );
  scre_site_equip eq_u (.mclk(mclk), .drive(drive), .rout(rout), .rin(rin));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  function automatic logic [31:0] rule_w(input logic [5:0] a, b,
    input logic sa, sb, input logic [1:0] o2, input logic [2:0] d,
    input logic lat, lg, input logic [1:0] sv);
    return {8'h00, 1'b1, sv, lg, lat, d, o2, sb, sa, b, a};
  endfunction

  task automatic bus(input logic wt, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    addr <= a;
    wr <= wt;
    rd <= !wt;
    wdata <= d;
    do begin
      @(posedge mclk);
      k++;
    end while (wait_req !== 1'b0 && k < 50);
    if (k == 50) begin
      errors++;
      finish_test();
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, m);
    rq.push_back({m, e});
    bus(1'b0, a, 32'h00000000);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Read answers and log events are matched against the oldest note
  always @(posedge mclk) begin
    if (rd && wait_req === 1'b0) begin
      n = rq.pop_front();
      `SCRE_CHK(rdata & n[63:32], n[31:0])
    end
    if (evt === 1'b1) begin
      l = lq.size() > 0 ? lq.pop_front() : 5'h1F;
      `SCRE_CHK({lrule, lsev}, l)
      `SCRE_CHK(ralm, 1'b1)
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    finish_test();
  end

  initial begin
    seed = 27;
    errors = 0;
    num_checks = 0;
    arst_n = 1'b0;
    {rd, wr, addr, wdata, drive, alarm, status, lrst} = '0;
    ce = 1'b1;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    rd_chk(8'h00, 32'h00000000, 32'hFFFFFFFF);
    rd_chk(8'h3C, 32'h00000000, 32'hFFFFFFFF);
    r = $random(seed);
    alarm <= r[15:0];
    status <= r[31:16];
    for (int j = 0; j < 16; j++) begin
      v = $random(seed);
      o[j] = (v[0] ? r[16 + v[5:2]] : r[v[5:2]]) ^ v[6];
      w = {25'h0, v[6:2], v[0] ? 2'h2 : 2'h1};
      bus(1'b1, 8'h80 + 8'(4 * j), w);
    end
    repeat (3) @(posedge mclk);
    rd_chk(8'h0C, {16'h0, o}, 32'h0000FFFF);
    rd_chk(8'hBC, w, 32'hFFFFFFFF);
    bus(1'b1, 8'h84, 32'h00000043);
    for (int k = 0; k < 16; k++) begin
      v = $random(seed);
      op = k[3:2];
      alarm[3] <= k[0];
      status[5] <= k[1];
      ea = k[0] ~^ v[0];
      eb = k[1] ~^ v[1];
      c = op == 2'h0 ? ea : op == 2'h1 ? ea & eb : op == 2'h2 ? ea | eb
        : ea ^ eb;
      bus(1'b1, 8'hC0, rule_w(6'h03, 6'h15, v[0], v[1], op, 3'h0, 1'b0,
        1'b0, 2'h0));
      repeat (2) @(posedge mclk);
      rd_chk(8'h08, {23'h0, c, 7'h0, c}, 32'h00000101);
      rd_chk(8'h0C, {30'h0, !c, 1'b0}, 32'h00000002);
    end
    for (int d = 1; d < 7; d++) begin
      s = d == 1 ? 40 : d == 2 ? 80 : d == 3 ? 200 : d == 4 ? 400
        : d == 5 ? 1200 : 2400;
      alarm[3] <= 1'b0;
      bus(1'b1, 8'hC0, rule_w(6'h03, 6'h00, 1'b1, 1'b0, 2'h0, 3'(d),
        1'b0, 1'b1, 2'(d % 3)));
      alarm[3] <= 1'b1;
      repeat (s - 10) @(posedge mclk);
      alarm[3] <= 1'b0;
      @(posedge mclk);
      alarm[3] <= 1'b1;
      lq.push_back({3'h0, 2'(d % 3)});
      repeat (s - 10) @(posedge mclk);
      rd_chk(8'h08, 32'h00000000, 32'h00000001);
      repeat (10) @(posedge mclk);
      rd_chk(8'h08, 32'h00000001, 32'h00000001);
    end
    bus(1'b1, 8'hC0, rule_w(6'h03, 6'h00, 1'b1, 1'b0, 2'h0, 3'h0, 1'b1,
      1'b0, 2'h0));
    bus(1'b1, 8'h48, 32'h00000060);
    for (int i = 0; i < 3; i++) begin
      alarm[3] <= 1'b1;
      repeat (3) @(posedge mclk);
      alarm[3] <= 1'b0;
      repeat (3) @(posedge mclk);
      rd_chk(8'h08, 32'h00000001, 32'h00000001);
      if (i == 0) begin
        lrst <= 1'b1;
        @(posedge mclk);
        lrst <= 1'b0;
      end else if (i == 1) begin
        bus(1'b1, 8'h00, 32'h00000002);
      end else begin
        // Reset input needs one more cycle than local reset to reach the rule
        drive <= 9'h004;
        repeat (2) @(posedge mclk);
      end
      repeat (3) @(posedge mclk);
      rd_chk(8'h08, 32'h00000000, 32'h00000001);
    end
    bus(1'b1, 8'h40, 32'h00000010);
    bus(1'b1, 8'h44, 32'h00000056);
    bus(1'b1, 8'hC0, rule_w(6'h20, 6'h00, 1'b1, 1'b0, 2'h0, 3'h0, 1'b0,
      1'b0, 2'h0));
    drive <= 9'h003;
    repeat (4) @(posedge mclk);
    rd_chk(8'h04, 32'h00020003, 32'h00030003);
    rd_chk(8'h08, 32'h00000000, 32'h00000001);
    rd_chk(8'h44, 32'h00000056, 32'hFFFFFFFF);
    bus(1'b1, 8'h00, 32'h00000001);
    repeat (3) @(posedge mclk);
    rd_chk(8'h04, 32'h00030003, 32'h00030003);
    rd_chk(8'h08, 32'h00000001, 32'h00000001);
    drive <= 9'h001;
    repeat (2) @(posedge mclk);
    drive <= 9'h003;
    repeat (3) @(posedge mclk);
    rd_chk(8'h04, 32'h00010003, 32'h00030003);
    ce <= 1'b0;
    drive <= 9'h000;
    repeat (4) @(posedge mclk);
    `SCRE_CHK(rout[1], 1'b0)
    ce <= 1'b1;
    repeat (5) @(posedge mclk);
    `SCRE_CHK(rout[1], 1'b1)
    repeat (3) @(posedge mclk);
    `SCRE_CHK(32'(lq.size()), 32'h00000000)
    finish_test();
  end
endmodule
